// ===== dv/pin_partner.sv
/*
 * Far-side model of the timer: external count clock pin and the
 * shared channel A pin. Assumes the bench clock and the timer's pin
 * output and enable are wired straight in.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_partner (
    input  wire logic i_ref_clk,
    input  wire logic i_ext_run,
    input  wire logic i_cap_level,
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe,
    output logic      o_ext_pin,
    output logic      o_pin_level
);
    logic [2:0] div;

    // ------------------------------------------------------------
    // External clock: toggles every 5 cycles, low between bursts
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_ext_run) begin
            div       <= 3'h0;
            o_ext_pin <= 1'b0;
        end else if (div == 3'h4) begin
            div       <= 3'h0;
            o_ext_pin <= ~o_ext_pin;
        end else begin
            div <= div + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Shared pin: the timer's driver wins while enabled
    // ------------------------------------------------------------
    assign o_pin_level = i_pin_oe ? i_pin_out : i_cap_level;
endmodule // pin_partner

`default_nettype wire

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the channel A timer control section.
 * Assumes the AHB-Lite slave, the pin partner and a 20 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "enh_timer_consts.svh"

module tb_top
    import enh_timer_pkg::*;
;
    logic        i_ref_clk, i_resetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, v, mx, hi, h2;
    logic [1:0]  htrans, tdiv;
    logic [2:0]  hsize;
    logic        hi_tick, tb_tick, ext_pin, pin_in, pin_out, pin_oe;
    logic        ext_run, cap_level, e;
    logic [9:0]  count, c1, d;
    int          bad_count, checks_done, n;
    int          per[8] = '{4, 1, 32, 128, 3, 0, 10, 10};

    enh_timer_ctrl uut (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .i_high_clock_tick(hi_tick), .i_timebase_tick(tb_tick),
        .i_ext_count_clock_pin(ext_pin), .i_chan_a_pin(pin_in),
        .o_chan_a_pin(pin_out), .o_chan_a_pin_oe(pin_oe), .o_count(count));

    pin_partner far (
        .i_ref_clk(i_ref_clk), .i_ext_run(ext_run),
        .i_cap_level(cap_level), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .o_ext_pin(ext_pin), .o_pin_level(pin_in));

    // ------------------------------------------------------------
    // Clock and tick sources
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk) begin
        hi_tick <= ~hi_tick;
        tdiv    <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
        tb_tick <= (tdiv == 2'h2);
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge i_ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (k >= 64) begin
            bad_count++;
            summarize();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_ref_clk);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic [31:0] r;
        bus(1'b1, a, dat, r);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dat);
        bus(1'b0, a, 32'h0, dat);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_ref_clk);
    endtask

    task automatic watch(input int k, output logic [31:0] m,
                         output logic [31:0] h);
        m = 32'h0;
        h = 32'h0;
        repeat (k) begin
            @(negedge i_ref_clk);
            if (count > m)
                m = {22'h0, count};
            if (pin_out === 1'b1)
                h++;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {i_resetn, hwrite, hi_tick, tb_tick, ext_run, cap_level} = 6'h0;
        {hsel, hsize, htrans, tdiv} = 8'hc0;
        hsize = 3'h2;
        {haddr, hwdata} = 64'h0;
        {bad_count, checks_done} = 0;
        repeat (16) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        rd(`OFS_CTRL0, v);
        check(v, 32'h0);
        rd(`OFS_CTRL1, v);
        check(v, 32'h0);
        wr(8'h10, 32'hff);
        rd(8'h10, v);
        check(v, 32'h0);
        wr(`OFS_CTRL1, 32'h03);
        rd(`OFS_CTRL1, v);
        check(v, 32'h01);
        wr(`OFS_CTRL1, 32'h00);
        ext_run <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            wr(`OFS_CTRL0, {24'h0, 1'b0, s[2:0], 4'h8});
            cyc(4);
            @(negedge i_ref_clk);
            c1 = count;
            n = (per[s] == 0) ? 100 : per[s] * 10;
            repeat (n) @(negedge i_ref_clk);
            d = count - c1;
            check(d, (per[s] == 0) ? 0 : 10);
        end
        ext_run <= 1'b0;
        wr(`OFS_CTRL0, 32'h18);
        cyc(20);
        wr(`OFS_CTRL0, 32'h98);
        cyc(2);
        @(negedge i_ref_clk);
        c1 = count;
        cyc(20);
        check(count, c1);
        wr(`OFS_CTRL0, 32'h18);
        cyc(2);
        @(negedge i_ref_clk);
        d = count - c1;
        check(d > 0 && d < 10, 1'b1);
        wr(`OFS_CTRL0, 32'h10);
        cyc(2);
        @(negedge i_ref_clk);
        c1 = count;
        cyc(20);
        check(count, c1);
        wr(`OFS_CTRL0, 32'h18);
        cyc(2);
        @(negedge i_ref_clk);
        check(count < 6, 1'b1);
        wr(`OFS_COMPARE_A, 32'd600);
        for (int r = 0; r < 4; r++) begin
            wr(`OFS_CTRL0, 32'h10);
            wr(`OFS_CTRL1, (r == 3) ? 32'h41 : {31'h0, r[1]});
            wr(`OFS_CTRL0, (r == 1) ? 32'h18 : 32'h19);
            n = (r == 1) ? 1023 : ((r == 2) ? 600 : 127);
            watch(r == 1 ? 1100 : (r == 2 ? 700 : 300), mx, hi);
            check(mx, n);
        end
        wr(`OFS_COMPARE_A, 32'd20);
        for (int f = 0; f < 16; f++) begin
            wr(`OFS_CTRL0, 32'h10);
            wr(`OFS_CTRL1, {24'h0, 2'h0, f[1:0], f[3], f[2], 2'h1});
            wr(`OFS_CTRL0, 32'h18);
            cyc(2);
            @(negedge i_ref_clk);
            check(pin_oe, 1'b1);
            check(pin_out, f[3] ^ f[2]);
            e = (f[1] ^ f[0]) ? f[1] : f[3] ^ f[0];
            watch(30, mx, hi);
            check(pin_out, e ^ f[2]);
            check(mx <= 20, 1'b1);
        end
        wr(`OFS_CTRL0, 32'h10);
        wr(`OFS_CTRL1, 32'hcc);
        wr(`OFS_CTRL0, 32'h18);
        cyc(3);
        check(pin_oe, 1'b0);
        wr(`OFS_COMPARE_A, 32'd32);
        for (int f = 0; f < 3; f++) begin
            wr(`OFS_CTRL0, 32'h10);
            wr(`OFS_CTRL1, {24'h0, 2'b10, f[1:0], 4'h8});
            wr(`OFS_CTRL0, 32'h19);
            cyc(10);
            watch(256, mx, hi);
            check(hi, f == 0 ? 0 : (f == 1 ? 256 : 64));
        end
        wr(`OFS_CTRL0, 32'h10);
        wr(`OFS_CTRL1, 32'hb8);
        wr(`OFS_COMPARE_A, 32'd30);
        ext_run <= 1'b1;
        watch(8, mx, hi);
        ext_run <= 1'b0;
        watch(92, mx, h2);
        check(hi + h2 >= 25 && hi + h2 <= 40, 1'b1);
        rd(`OFS_CTRL0, v);
        check(v, 32'h10);
        for (int f = 0; f < 4; f++) begin
            wr(`OFS_CTRL0, 32'h10);
            wr(`OFS_CTRL1, {24'h0, 2'b01, f[1:0], 4'h0});
            wr(`OFS_COMPARE_A, 32'h3ff);
            wr(`OFS_CTRL0, 32'h18);
            cyc(20);
            cap_level <= 1'b1;
            cyc(10);
            rd(`OFS_COMPARE_A, v);
            check(v != 32'h3ff, f == 0 || f == 2);
            check(pin_oe, 1'b0);
            wr(`OFS_COMPARE_A, 32'h3ff);
            cap_level <= 1'b0;
            cyc(10);
            rd(`OFS_COMPARE_A, v);
            check(v != 32'h3ff, f == 1 || f == 2);
        end
        // Reset in mid-run while the counter is running
        i_resetn <= 1'b0;
        cyc(2);
        i_resetn <= 1'b1;
        rd(`OFS_COUNT, v);
        check(v, 32'h0);
        rd(`OFS_CTRL0, v);
        check(v, 32'h0);
        rd(`OFS_CTRL1, v);
        check(v, 32'h0);
        check({hresp, hreadyout}, 2'h1);
        summarize();
    end

    initial begin
        repeat (90000) @(posedge i_ref_clk);
        bad_count++;
        summarize();
    end
endmodule // tb_top

`default_nettype wire

// ===== logic/enh_timer_consts.svh
/*
 * Constants for the channel A control section of the 10-bit timer:
 * register offsets, field codes, reset values and counts.
 * Assumes one 20 MHz clock and a 32-bit AHB-Lite register bus.
 */
`ifndef ENH_TIMER_CONSTS_SVH
`define ENH_TIMER_CONSTS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_COMPARE_A  8'h08
`define OFS_COUNT      8'h0c

// ------------------------------------------------------------------
// Reset values and field constants
// ------------------------------------------------------------------
`define CTRL0_RESET    8'h00
`define CTRL1_RESET    8'h00
`define COMPARE_A_RESET 10'h000
`define CLK_SYS_DIV4   3'h0
`define CLK_SYS        3'h1
`define CLK_HIGH_DIV16 3'h2
`define CLK_HIGH_DIV64 3'h3
`define CLK_TIMEBASE   3'h4
`define CLK_RESERVED   3'h5
`define CLK_EXT_RISE   3'h6
`define CLK_EXT_FALL   3'h7
`define PERIOD_LOW_MAX 7'h7f
`define SYS_DIV4_LAST  2'h3
`define HIGH_DIV16_LAST 4'hf
`define HIGH_DIV64_LAST 6'h3f

`endif

// ===== logic/enh_timer_ctrl.sv
/*
 * Channel A control section of a 10-bit timer with an AHB-Lite slave.
 * Assumes single word transfers, synchronous pin inputs and one-cycle
 * tick strobes for the high and timebase clocks.
 */
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "enh_timer_consts.svh"

module enh_timer_ctrl
    import enh_timer_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_clk_en,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        i_high_clock_tick,
    input  wire logic        i_timebase_tick,
    input  wire logic        i_ext_count_clock_pin,
    input  wire logic        i_chan_a_pin,
    output logic             o_chan_a_pin,
    output logic             o_chan_a_pin_oe,
    output logic [9:0]       o_count
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    ctrl0_s     ctrl0;
    ctrl1_s     ctrl1;
    logic [9:0] compare_a;
    logic [9:0] count;
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       addr_ok;
    logic       wr_ctrl0;
    logic       wr_ctrl1;
    logic       wr_cmp;
    logic [31:0] next_rdata;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && hready && htrans[1];

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (i_clk_en) begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    assign wr_ctrl0 = wr_pend && wr_addr == `OFS_CTRL0;
    assign wr_ctrl1 = wr_pend && wr_addr == `OFS_CTRL1;
    assign wr_cmp   = wr_pend && wr_addr == `OFS_COMPARE_A;

    always_comb begin
        case (haddr[7:0])
            `OFS_CTRL0:     next_rdata = {24'h000000, ctrl0};
            `OFS_CTRL1:     next_rdata = {24'h000000, ctrl1};
            `OFS_COMPARE_A: next_rdata = {22'h0, compare_a};
            `OFS_COUNT:     next_rdata = {22'h0, count};
            default:        next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            hrdata <= 32'h00000000;
        end else if (i_clk_en && addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    chan_mode_e mode;
    logic       single_pulse;
    logic       on_prev;
    logic       on_rise;
    logic       running;

    assign mode = chan_mode_e'(ctrl1.chan_a_mode_field);
    assign single_pulse = mode == MODE_PWM
                       && ctrl1.chan_a_pin_function == 2'h3;
    assign on_rise = ctrl0.timer_on_bit && !on_prev;
    assign running = ctrl0.timer_on_bit
                  && !ctrl0.pause_bit;

    // ------------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------------
    logic [1:0] sys_div;
    logic [5:0] high_div;
    logic       ext_q;
    logic       ext_prev;
    logic       ext_rise;
    logic       ext_fall;
    logic       tick;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            sys_div <= 2'h0;
        end else if (i_clk_en) begin
            sys_div <= sys_div + 2'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            high_div <= 6'h00;
        end else if (i_clk_en && i_high_clock_tick) begin
            high_div <= high_div + 6'h01;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ext_q    <= 1'b0;
            ext_prev <= 1'b0;
        end else if (i_clk_en) begin
            ext_q    <= i_ext_count_clock_pin;
            ext_prev <= ext_q;
        end
    end

    assign ext_rise = ext_q && !ext_prev;
    assign ext_fall = !ext_q && ext_prev;

    always_comb begin
        case (ctrl0.count_clock_select)
            `CLK_SYS_DIV4:   tick = sys_div == `SYS_DIV4_LAST;
            `CLK_SYS:        tick = 1'b1;
            `CLK_HIGH_DIV16: tick = i_high_clock_tick
                                 && high_div[3:0] == `HIGH_DIV16_LAST;
            `CLK_HIGH_DIV64: tick = i_high_clock_tick
                                 && high_div == `HIGH_DIV64_LAST;
            `CLK_TIMEBASE:   tick = i_timebase_tick;
            `CLK_EXT_RISE:   tick = ext_rise;
            `CLK_EXT_FALL:   tick = ext_fall;
            default:         tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter and comparators
    // ------------------------------------------------------------------
    logic [9:0] count_inc;
    logic       step;
    logic       period_hit;
    logic       match_a;
    logic       clear_by_a;
    logic       wrap_clear;

    assign step      = i_clk_en && running && tick;
    assign count_inc = count + 10'h001;
    // Period zero makes the match coincide with the natural overflow
    assign period_hit = count_inc[9:7] == ctrl0.period_value
                     && count_inc[6:0] == 7'h00;
    assign match_a    = step && count == compare_a;
    assign clear_by_a = ctrl1.clear_select && !single_pulse
                     && mode != MODE_CAPTURE;
    assign wrap_clear = single_pulse ? 1'b0
                      : clear_by_a ? match_a
                      : period_hit;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            on_prev <= 1'b0;
        end else if (i_clk_en) begin
            on_prev <= ctrl0.timer_on_bit;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            count <= 10'h000;
        end else if (i_clk_en && on_rise) begin
            count <= 10'h000;
        end else if (step) begin
            count <= wrap_clear ? 10'h000 : count_inc;
        end
    end

    assign o_count = count;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic ext_start;
    logic pulse_end;

    assign ext_start = single_pulse && ext_rise;
    assign pulse_end = single_pulse && match_a;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ctrl0 <= `CTRL0_RESET;
        end else if (i_clk_en) begin
            if (wr_ctrl0) begin
                ctrl0 <= hwdata[7:0];
            end else if (ext_start) begin
                ctrl0.timer_on_bit <= 1'b1;
            end else if (pulse_end) begin
                ctrl0.timer_on_bit <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ctrl1 <= `CTRL1_RESET;
        end else if (i_clk_en && wr_ctrl1) begin
            ctrl1 <= {hwdata[7:2], 1'b0, hwdata[0]};
        end
    end

    // ------------------------------------------------------------------
    // Capture and compare A register
    // ------------------------------------------------------------------
    logic pin_q;
    logic pin_prev;
    logic cap_edge;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pin_q    <= 1'b0;
            pin_prev <= 1'b0;
        end else if (i_clk_en) begin
            pin_q    <= i_chan_a_pin;
            pin_prev <= pin_q;
        end
    end

    always_comb begin
        case (ctrl1.chan_a_pin_function)
            2'h0:    cap_edge = pin_q && !pin_prev;
            2'h1:    cap_edge = !pin_q && pin_prev;
            2'h2:    cap_edge = pin_q != pin_prev;
            default: cap_edge = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            compare_a <= `COMPARE_A_RESET;
        end else if (i_clk_en) begin
            if (mode == MODE_CAPTURE && cap_edge) begin
                compare_a <= count;
            end else if (wr_cmp) begin
                compare_a <= hwdata[9:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel A output
    // ------------------------------------------------------------------
    logic cmp_level;
    logic active;
    logic pin_level;
    logic oc;

    assign oc = ctrl1.chan_a_output_control;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            cmp_level <= 1'b0;
        end else if (i_clk_en && mode == MODE_COMPARE) begin
            if (on_rise) begin
                cmp_level <= oc;
            end else if (match_a) begin
                case (ctrl1.chan_a_pin_function)
                    2'h1:    cmp_level <= oc ? 1'b0 : cmp_level;
                    2'h2:    cmp_level <= oc ? cmp_level : 1'b1;
                    2'h3:    cmp_level <= !cmp_level;
                    default: cmp_level <= cmp_level;
                endcase
            end
        end
    end

    always_comb begin
        case (ctrl1.chan_a_pin_function)
            2'h0:    active = 1'b0;
            2'h1:    active = 1'b1;
            2'h2:    active = ctrl0.timer_on_bit && count < compare_a;
            default: active = ctrl0.timer_on_bit;
        endcase
    end

    assign pin_level = mode == MODE_COMPARE ? cmp_level
                     : active ? oc : !oc;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_chan_a_pin    <= 1'b0;
            o_chan_a_pin_oe <= 1'b0;
        end else if (i_clk_en) begin
            o_chan_a_pin    <= pin_level ^ ctrl1.chan_a_polarity;
            o_chan_a_pin_oe <= mode == MODE_COMPARE || mode == MODE_PWM;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    pause_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_clk_en && ctrl0.pause_bit && !on_rise |=> $stable(count))
        else $error("count moved while paused");

    reserved_clk_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        i_clk_en && !on_rise
        && ctrl0.count_clock_select == `CLK_RESERVED
        |=> $stable(count))
        else $error("reserved clock code moved the count");

    off_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_clk_en && !ctrl0.timer_on_bit |=> $stable(count))
        else $error("count moved while off");

    on_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_clk_en && on_rise |=> count == 10'h000)
        else $error("count not cleared on switch-on");

    init_level_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        i_clk_en && on_rise && mode == MODE_COMPARE
        |=> cmp_level == $past(oc))
        else $error("pin not returned to initial level");

    period_clr_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        step && !on_rise && !clear_by_a && !single_pulse
        && count[9:7] == ctrl0.period_value - 3'h1
        && count[6:0] == `PERIOD_LOW_MAX |=> count == 10'h000)
        else $error("period match did not clear the counter");

    cmp_a_clr_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        match_a && !on_rise && clear_by_a |=> count == 10'h000)
        else $error("compare A match did not clear the counter");

    toggle_out_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        match_a && !on_rise && mode == MODE_COMPARE
        && ctrl1.chan_a_pin_function == 2'h3
        |=> cmp_level != $past(cmp_level))
        else $error("toggle on compare match missing");

    polarity_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_resetn)
        i_clk_en && mode == MODE_COMPARE
        |=> o_chan_a_pin == ($past(cmp_level)
                           ^ $past(ctrl1.chan_a_polarity)))
        else $error("pin polarity wrong");

    capture_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_clk_en && mode == MODE_CAPTURE && cap_edge
        |=> compare_a == $past(count))
        else $error("capture did not store the count");

    dir_up_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        step && !on_rise && !wrap_clear
        |=> count == $past(count_inc) && !ctrl1.direction_flag)
        else $error("counter not counting up by one");

endmodule // enh_timer_ctrl

`default_nettype wire

// ===== logic/enh_timer_pkg.sv
/*
 * Types for the channel A timer control section.
 * Assumes the constants header supplies offsets and reset values.
 */
`default_nettype none
package enh_timer_pkg;

    typedef struct packed {
        logic       pause_bit;
        logic [2:0] count_clock_select;
        logic       timer_on_bit;
        logic [2:0] period_value;
    } ctrl0_s;

    typedef struct packed {
        logic [1:0] chan_a_mode_field;
        logic [1:0] chan_a_pin_function;
        logic       chan_a_output_control;
        logic       chan_a_polarity;
        logic       direction_flag;
        logic       clear_select;
    } ctrl1_s;

    typedef enum logic [1:0] {
        MODE_COMPARE,
        MODE_CAPTURE,
        MODE_PWM,
        MODE_TIMER
    } chan_mode_e;

endpackage
`default_nettype wire
